/* src/system_power_mode_controller.sv */
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
// How it works
// - Protection register takes one write per reset, later writes ignored.
// - One allow bit governs all very-low-leakage stop sub-modes.
// - Sleep request with deep-sleep flag enters the selected stop mode.
// - Stop mode select writes blocked unless that mode is allowed.
// - Successful protection write clears stop mode select.
// - Stop select codes 000, 010, 011, 100 valid; others reserved.
// - Sub-mode codes 001, 010, 011 valid; others reserved.
// - Wake during stop entry aborts to run and sets stop-aborted flag.
// - Mode status reads 04 in very-low-power run.
// - Regulator run status clear in stop regulation or transition.
// - Pads and oscillator held until software clears isolation ack.
// - Wake from very-low-leakage stop goes through reset flow.
// - RAM partition two power bit keeps it powered in level 2.
// - Isolation ack reads latched state, cleared by writing one.
`include "pmode_map.svh"
module system_power_mode_controller (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Core sleep handshake
  input  wire logic               sleep_req,
  input  wire logic               core_deep_sleep_flag,
  // Asynchronous wake and recovery
  input  wire logic               wake_irq,
  input  wire logic               vlls_recovery,
  // Power controls
  output pmode_pkg::pwr_ctl_t     pwr_ctl,
  output logic                    regulator_run_status,
  output logic      [7:0]         current_mode_status,
  output logic                    irq
);
  import pmode_pkg::*;

  logic [1:0] wake_sync_ff;
  logic [1:0] rec_sync_ff;
  logic       wake_s;
  logic       rec_s;
  pm_state_t  state_ff,    nxt_state;
  logic [3:0] cnt_ff,      nxt_cnt;
  logic       locked_ff,   nxt_locked;
  logic [7:0] prot_ff,     nxt_prot;
  logic [2:0] stop_mode_select_ff,    nxt_stop_mode_select;
  logic       stop_aborted_ff,    nxt_stop_aborted;
  logic [1:0] runm_ff,     nxt_runm;
  logic [2:0] subm_ff,     nxt_subm;
  logic       ram2_ff,     nxt_ram2;
  logic [2:0] target_ff,   nxt_target;
  logic [7:0] mstat_ff,    nxt_mstat;
  logic       iso_ff,      nxt_iso;
  logic [1:0] boot_ff,     nxt_boot;
  logic [7:0] isr_ff,      nxt_isr;
  logic [7:0] imr_ff,      nxt_imr;
  logic [31:0] rdata_ff,   nxt_rdata;
  logic [3:0] age_ff,      nxt_age;
  logic       wr;
  logic       rd;
  logic       hit;
  logic [2:0] idx;

  function automatic logic stop_mode_select_allowed(input logic [2:0] code, input logic [7:0] prot);
    logic ok;
    ok = 1'b0;
    if (code == `STOP_MODE_SELECT_NORMAL) begin
      ok = 1'b1;
    end else if (code == `STOP_MODE_SELECT_VERY_LOW_POWER_STOP) begin
      ok = prot[`PROT_AVLP_BIT];
    end else if (code == `STOP_MODE_SELECT_LLS) begin
      ok = prot[`PROT_ALLOW_LOW_LEAKAGE_STOP_BIT];
    end else if (code == `STOP_MODE_SELECT_VLLS) begin
      ok = prot[`PROT_ALLOW_DEEP_LEAKAGE_STOP_BIT];
    end
    return ok;
  endfunction

  function automatic logic [7:0] mode_code(input logic [2:0] code);
    logic [7:0] m;
    m = `MS_STOP;
    if (code == `STOP_MODE_SELECT_VERY_LOW_POWER_STOP) begin
      m = `MS_VERY_LOW_POWER_STOP;
    end else if (code == `STOP_MODE_SELECT_LLS) begin
      m = `MS_LLS;
    end else if (code == `STOP_MODE_SELECT_VLLS) begin
      m = `MS_VLLS;
    end
    return m;
  endfunction

  assign wake_s = wake_sync_ff[1];
  assign rec_s  = rec_sync_ff[1];

  // Address decode
  assign idx     = paddr[4:2];
  assign hit     = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00) && (idx <= `IDX_IMR);
  assign wr      = psel && penable && pwrite && hit;
  assign rd      = psel && !penable && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = rdata_ff;

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_locked = locked_ff;
    nxt_prot   = prot_ff;
    nxt_stop_mode_select  = stop_mode_select_ff;
    nxt_stop_aborted  = stop_aborted_ff;
    nxt_runm   = runm_ff;
    nxt_subm   = subm_ff;
    nxt_ram2   = ram2_ff;
    nxt_target = target_ff;
    nxt_mstat  = mstat_ff;
    nxt_iso    = iso_ff;
    nxt_boot   = (boot_ff == 2'h3) ? boot_ff : boot_ff + 2'h1;
    nxt_isr    = isr_ff;
    nxt_imr    = imr_ff;
    nxt_rdata  = rdata_ff;
    // Register writes
    if (wr) begin
      if (idx == `IDX_PROT) begin
        if (!locked_ff) begin
          nxt_locked = 1'b1;
          nxt_prot   = pwdata[7:0] & `PROT_WMASK;
          nxt_stop_mode_select  = `STOP_MODE_SELECT_NORMAL;
        end
      end else if (idx == `IDX_CTRL) begin
        if (stop_mode_select_allowed(pwdata[2:0], prot_ff)) begin
          nxt_stop_mode_select = pwdata[2:0];
        end
        if (state_ff == ST_RUN && pwdata[6:5] == `RUNM_VERY_LOW_POWER_RUN && prot_ff[`PROT_AVLP_BIT]) begin
          nxt_runm  = `RUNM_VERY_LOW_POWER_RUN;
          nxt_mstat = `MS_VERY_LOW_POWER_RUN;
        end else if (state_ff == ST_RUN && pwdata[6:5] == `RUNM_NORMAL) begin
          nxt_runm  = `RUNM_NORMAL;
          nxt_mstat = `MS_RUN;
        end
      end else if (idx == `IDX_DLCTRL) begin
        nxt_subm = pwdata[2:0];
        nxt_ram2 = pwdata[`DL_RAM2_BIT];
      end else if (idx == `IDX_REGSC) begin
        if (pwdata[`REGSC_ACK_BIT]) begin
          nxt_iso = 1'b0;
        end
      end else if (idx == `IDX_ISR) begin
        nxt_isr = isr_ff & ~pwdata[7:0];
      end else if (idx == `IDX_IMR) begin
        nxt_imr = pwdata[7:0] & `EV_MASK;
      end
    end
    // Read data
    if (rd) begin
      nxt_rdata = 32'h0000_0000;
      if (!hit) begin
        nxt_rdata = 32'h0000_0000;
      end else if (idx == `IDX_PROT) begin
        nxt_rdata[7:0] = prot_ff;
      end else if (idx == `IDX_CTRL) begin
        nxt_rdata[7:0] = {1'b0, runm_ff, 1'b0, stop_aborted_ff, stop_mode_select_ff};
      end else if (idx == `IDX_DLCTRL) begin
        nxt_rdata[7:0] = {3'h0, ram2_ff, 1'b0, subm_ff};
      end else if (idx == `IDX_STAT) begin
        nxt_rdata[7:0] = mstat_ff;
      end else if (idx == `IDX_REGSC) begin
        nxt_rdata[7:0] = {4'h0, iso_ff, regulator_run_status, 2'h0};
      end else if (idx == `IDX_ISR) begin
        nxt_rdata[7:0] = isr_ff;
      end else if (idx == `IDX_IMR) begin
        nxt_rdata[7:0] = imr_ff;
      end
    end
    if (boot_ff == 2'h2 && rec_s) begin
      nxt_iso = 1'b1;
    end
    case (state_ff)
      ST_RUN: begin
        if (sleep_req && core_deep_sleep_flag) begin
          if (stop_mode_select_ff != `STOP_MODE_SELECT_VLLS || (subm_ff >= `SUBM_L1 && subm_ff <= `SUBM_L3)) begin
            nxt_state  = ST_ENTER;
            nxt_cnt    = 4'h0;
            nxt_target = stop_mode_select_ff;
          end
        end
      end
      ST_ENTER: begin
        if (wake_s) begin
          nxt_state        = ST_RUN;
          nxt_stop_aborted        = 1'b1;
          nxt_isr[`EV_ABORTED] = 1'b1;
          nxt_mstat        = (runm_ff == `RUNM_VERY_LOW_POWER_RUN) ? `MS_VERY_LOW_POWER_RUN : `MS_RUN;
        end else if (cnt_ff == 4'(`ENTRY_CYC - 1)) begin
          nxt_state        = ST_STOP;
          nxt_stop_aborted        = 1'b0;
          nxt_isr[`EV_ENTERED] = 1'b1;
          nxt_mstat        = mode_code(target_ff);
          if (target_ff == `STOP_MODE_SELECT_VLLS) begin
            nxt_iso = 1'b1;
          end
        end else begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      ST_STOP: begin
        if (wake_s) begin
          if (target_ff == `STOP_MODE_SELECT_VLLS) begin
            nxt_state = ST_RFLOW;
          end else begin
            nxt_state = ST_EXIT;
            nxt_cnt   = 4'h0;
          end
        end
      end
      ST_EXIT: begin
        if (cnt_ff == 4'(`EXIT_CYC - 1)) begin
          nxt_state         = ST_RUN;
          nxt_isr[`EV_WOKE] = 1'b1;
          nxt_mstat         = (runm_ff == `RUNM_VERY_LOW_POWER_RUN) ? `MS_VERY_LOW_POWER_RUN : `MS_RUN;
        end else begin
          nxt_cnt = cnt_ff + 4'h1;
        end
      end
      ST_RFLOW: begin
        nxt_state = ST_RFLOW;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
    // Cycles spent in the present state
    nxt_age = (nxt_state == state_ff) ? age_ff + 4'h1 : 4'h0;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wake_sync_ff <= 2'h0;
      rec_sync_ff  <= 2'h0;
      state_ff     <= ST_RUN;
      cnt_ff       <= 4'h0;
      locked_ff    <= 1'b0;
      prot_ff      <= 8'h00;
      stop_mode_select_ff     <= `STOP_MODE_SELECT_NORMAL;
      stop_aborted_ff     <= 1'b0;
      runm_ff      <= `RUNM_NORMAL;
      subm_ff      <= `SUBM_L3;
      ram2_ff      <= 1'b1;
      target_ff    <= `STOP_MODE_SELECT_NORMAL;
      mstat_ff     <= `MS_RUN;
      iso_ff       <= 1'b0;
      boot_ff      <= 2'h0;
      isr_ff       <= 8'h00;
      imr_ff       <= 8'h00;
      rdata_ff     <= 32'h0000_0000;
      age_ff       <= 4'h0;
    end else begin
      wake_sync_ff <= {wake_sync_ff[0], wake_irq};
      rec_sync_ff  <= {rec_sync_ff[0], vlls_recovery};
      state_ff     <= nxt_state;
      cnt_ff       <= nxt_cnt;
      locked_ff    <= nxt_locked;
      prot_ff      <= nxt_prot;
      stop_mode_select_ff     <= nxt_stop_mode_select;
      stop_aborted_ff     <= nxt_stop_aborted;
      runm_ff      <= nxt_runm;
      subm_ff      <= nxt_subm;
      ram2_ff      <= nxt_ram2;
      target_ff    <= nxt_target;
      mstat_ff     <= nxt_mstat;
      iso_ff       <= nxt_iso;
      boot_ff      <= nxt_boot;
      isr_ff       <= nxt_isr;
      imr_ff       <= nxt_imr;
      rdata_ff     <= nxt_rdata;
      age_ff       <= nxt_age;
    end
  end

  // Outputs
  assign current_mode_status    = mstat_ff;
  assign irq                    = |(isr_ff & imr_ff);
  assign pwr_ctl.core_stop      = (state_ff == ST_STOP) || (state_ff == ST_RFLOW);
  assign pwr_ctl.pad_hold       = iso_ff;
  assign pwr_ctl.osc_hold       = iso_ff;
  assign pwr_ctl.ram2_power_en  = ram2_ff || (state_ff != ST_STOP) || (target_ff != `STOP_MODE_SELECT_VLLS)
                                  || (subm_ff != `SUBM_L2);
  assign pwr_ctl.reset_flow_req = (state_ff == ST_RFLOW);
  assign regulator_run_status   = (state_ff == ST_RUN && runm_ff == `RUNM_NORMAL)
                                  || (state_ff == ST_STOP && target_ff == `STOP_MODE_SELECT_NORMAL);

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_prot_once: assert property (locked_ff && wr && idx == `IDX_PROT |=> $stable(prot_ff))
    else $error("protection changed after lock");
  chk_deep_allow: assert property (stop_mode_select_ff == `STOP_MODE_SELECT_VLLS |-> prot_ff[`PROT_ALLOW_DEEP_LEAKAGE_STOP_BIT])
    else $error("deep select without allow");
  chk_sleep_entry: assert property (state_ff == ST_RUN && sleep_req && core_deep_sleep_flag
    && stop_mode_select_ff != `STOP_MODE_SELECT_VLLS |=> state_ff == ST_ENTER)
    else $error("sleep request not taken");
  chk_stop_mode_select_block: assert property (wr && idx == `IDX_CTRL && pwdata[2:0] == `STOP_MODE_SELECT_LLS
    && !prot_ff[`PROT_ALLOW_LOW_LEAKAGE_STOP_BIT] |=> $stable(stop_mode_select_ff))
    else $error("blocked select written");
  chk_prot_clear: assert property (!locked_ff && wr && idx == `IDX_PROT |=> stop_mode_select_ff == `STOP_MODE_SELECT_NORMAL)
    else $error("select not cleared");
  chk_stop_mode_select_valid: assert property (stop_mode_select_ff inside {3'h0, 3'h2, 3'h3, 3'h4})
    else $error("reserved select held");
  chk_abort_flag: assert property (state_ff == ST_ENTER && wake_s |=> stop_aborted_ff && state_ff == ST_RUN)
    else $error("abort not flagged");
  chk_very_low_power_run_code: assert property (state_ff == ST_RUN && runm_ff == `RUNM_VERY_LOW_POWER_RUN |-> mstat_ff == `MS_VERY_LOW_POWER_RUN)
    else $error("very_low_power_run status wrong");
  chk_reg_status: assert property (state_ff == ST_ENTER || state_ff == ST_EXIT |-> !regulator_run_status)
    else $error("regulator status in transition");
  chk_iso_hold: assert property (iso_ff && !(wr && idx == `IDX_REGSC && pwdata[`REGSC_ACK_BIT])
    |=> iso_ff)
    else $error("isolation released early");
  chk_entry_time: assert property (state_ff == ST_ENTER && age_ff == 4'(`ENTRY_CYC - 1) && !wake_s |=> state_ff == ST_STOP)
    else $error("entry time wrong");
  chk_entry_early: assert property (state_ff == ST_ENTER && age_ff < 4'(`ENTRY_CYC - 1) |=> state_ff != ST_STOP)
    else $error("entry finished early");
  chk_exit_time: assert property (state_ff == ST_EXIT && age_ff == 4'(`EXIT_CYC - 1) |=> state_ff == ST_RUN)
    else $error("exit time wrong");
  chk_lls_status: assert property (state_ff == ST_STOP && target_ff == `STOP_MODE_SELECT_LLS |-> mstat_ff == `MS_LLS)
    else $error("low leakage status wrong");
  chk_shallow_sleep: assert property (state_ff == ST_RUN && !core_deep_sleep_flag |=> state_ff == ST_RUN)
    else $error("shallow sleep entered stop");
  chk_submode_refuse: assert property (state_ff == ST_RUN && sleep_req && core_deep_sleep_flag
    && stop_mode_select_ff == `STOP_MODE_SELECT_VLLS && !(subm_ff inside {`SUBM_L1, `SUBM_L2, `SUBM_L3}) |=> state_ff == ST_RUN)
    else $error("reserved submode entered");
  chk_ram2_level: assert property (state_ff == ST_STOP && target_ff == `STOP_MODE_SELECT_VLLS && subm_ff == `SUBM_L2
    |-> pwr_ctl.ram2_power_en == ram2_ff)
    else $error("partition two power wrong");
  chk_deep_wake: assert property (state_ff == ST_STOP && target_ff == `STOP_MODE_SELECT_VLLS && wake_s |=> pwr_ctl.reset_flow_req)
    else $error("deep wake without reset flow");
  chk_iso_capture: assert property (boot_ff == 2'h2 && rec_s |=> iso_ff)
    else $error("isolation not captured");

  cov_stop_entry: cover property (state_ff == ST_ENTER ##1 state_ff == ST_STOP);
  cov_abort:      cover property (state_ff == ST_ENTER && wake_s);
  cov_deep_wake:  cover property (state_ff == ST_STOP ##1 state_ff == ST_RFLOW);
  cov_very_low_power_run_run:   cover property (state_ff == ST_RUN && runm_ff == `RUNM_VERY_LOW_POWER_RUN);
  cov_iso_free:   cover property (iso_ff ##1 !iso_ff);
endmodule

/* src/pmode_map.svh */
`ifndef PMODE_MAP_SVH
`define PMODE_MAP_SVH
// Register indices, byte address is four times the index
`define IDX_PROT        3'h0
`define IDX_CTRL        3'h1
`define IDX_DLCTRL      3'h2
`define IDX_STAT        3'h3
`define IDX_REGSC       3'h4
`define IDX_ISR         3'h5
`define IDX_IMR         3'h6
// Protection fields
`define PROT_ALLOW_DEEP_LEAKAGE_STOP_BIT  1
`define PROT_ALLOW_LOW_LEAKAGE_STOP_BIT   3
`define PROT_AVLP_BIT   5
`define PROT_WMASK      8'h2A
// Control fields
`define STOP_MODE_SELECT_NORMAL    3'h0
`define STOP_MODE_SELECT_VERY_LOW_POWER_STOP      3'h2
`define STOP_MODE_SELECT_LLS       3'h3
`define STOP_MODE_SELECT_VLLS      3'h4
`define CTRL_STOP_ABORTED_BIT  3
`define RUNM_NORMAL     2'h0
`define RUNM_VERY_LOW_POWER_RUN       2'h2
// Deep leakage control fields
`define SUBM_L1         3'h1
`define SUBM_L2         3'h2
`define SUBM_L3         3'h3
`define DL_RAM2_BIT     4
// Regulator and isolation fields
`define REGSC_REGON_BIT 2
`define REGSC_ACK_BIT   3
// Interrupt status bits
`define EV_ENTERED      0
`define EV_ABORTED      1
`define EV_WOKE         2
`define EV_MASK         8'h07
// Mode status codes
`define MS_RUN          8'h01
`define MS_STOP         8'h02
`define MS_VERY_LOW_POWER_RUN         8'h04
`define MS_VERY_LOW_POWER_STOP         8'h10
`define MS_LLS          8'h20
`define MS_VLLS         8'h40
// Timing
`define CLK_NS          50
`define ENTRY_NS        500
`define EXIT_NS         300
`define ENTRY_CYC       ((`ENTRY_NS + `CLK_NS - 1) / `CLK_NS)
`define EXIT_CYC        ((`EXIT_NS + `CLK_NS - 1) / `CLK_NS)
`endif

/* src/pmode_pkg.sv */
package pmode_pkg;
  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_ENTER  = 3'b001,
    ST_STOP   = 3'b010,
    ST_EXIT   = 3'b011,
    ST_RFLOW  = 3'b100
  } pm_state_t;

  typedef struct packed {
    logic core_stop;
    logic pad_hold;
    logic osc_hold;
    logic ram2_power_en;
    logic reset_flow_req;
  } pwr_ctl_t;
endpackage

/* tb/core_sleep_model.sv */
`timescale 1ns/100ps
module core_sleep_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Bench commands
  input  wire logic       sleep_go,
  input  wire logic [3:0] lag,
  input  wire logic       wake_go,
  input  wire logic       light,
  // Core side
  output logic            sleep_req,
  output logic            core_deep_sleep_flag,
  output logic            wake_irq
);
  logic [3:0] wait_ff;
  logic       pend_ff;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wait_ff              <= 4'h0;
      pend_ff              <= 1'b0;
      sleep_req            <= 1'b0;
      core_deep_sleep_flag <= 1'b0;
      wake_irq             <= 1'b0;
    end else begin
      wake_irq  <= wake_go;
      sleep_req <= 1'b0;
      if (sleep_go) begin
        pend_ff <= 1'b1;
        wait_ff <= lag;
      end else if (pend_ff && wait_ff != 4'h0) begin
        wait_ff <= wait_ff - 4'h1;
      end else if (pend_ff) begin
        pend_ff   <= 1'b0;
        sleep_req <= 1'b1;
      end
      core_deep_sleep_flag <= (pend_ff || sleep_go) && !light;
    end
  end
endmodule

/* tb/test_system_power_mode_controller.sv */
`timescale 1ns/100ps
`include "pmode_map.svh"
module test_system_power_mode_controller;
  import pmode_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic        vlls_recovery = 1'b0;
  logic        sleep_go = 1'b0;
  logic        wake_go = 1'b0;
  logic        light = 1'b0;
  logic [3:0]  lag = 4'h0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, last_err, sleep_req, core_deep_sleep_flag, wake_irq, regulator_run_status, irq;
  pwr_ctl_t    pwr_ctl;
  logic [7:0]  current_mode_status;
  logic [7:0]  rnd = 8'h17;
  logic [2:0]  code, sel;
  int          fails, compares, n;

  always #25 clk_sys = ~clk_sys;

  system_power_mode_controller system_power_mode_controller_i (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sleep_req(sleep_req), .core_deep_sleep_flag(core_deep_sleep_flag), .wake_irq(wake_irq),
    .vlls_recovery(vlls_recovery), .pwr_ctl(pwr_ctl), .regulator_run_status(regulator_run_status),
    .current_mode_status(current_mode_status), .irq(irq));
  core_sleep_model core_sleep_model_i (.clk_sys(clk_sys), .rstn(rstn), .sleep_go(sleep_go), .lag(lag),
    .wake_go(wake_go), .light(light), .sleep_req(sleep_req), .core_deep_sleep_flag(core_deep_sleep_flag),
    .wake_irq(wake_irq));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [2:0] exp_sel(input logic [2:0] old, input logic [2:0] c, input logic [7:0] p);
    case (c)
      `STOP_MODE_SELECT_NORMAL: return c;
      `STOP_MODE_SELECT_VERY_LOW_POWER_STOP: return p[`PROT_AVLP_BIT] ? c : old;
      `STOP_MODE_SELECT_LLS: return p[`PROT_ALLOW_LOW_LEAKAGE_STOP_BIT] ? c : old;
      `STOP_MODE_SELECT_VLLS: return p[`PROT_ALLOW_DEEP_LEAKAGE_STOP_BIT] ? c : old;
      default: return old;
    endcase
  endfunction
  function automatic logic [7:0] exp_stat(input logic [2:0] c);
    case (c)
      `STOP_MODE_SELECT_NORMAL: return `MS_STOP;
      `STOP_MODE_SELECT_VERY_LOW_POWER_STOP: return `MS_VERY_LOW_POWER_STOP;
      `STOP_MODE_SELECT_LLS: return `MS_LLS;
      default: return `MS_VLLS;
    endcase
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    rdat     = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(name, rdat, exp);
  endtask
  task automatic do_reset(input logic rec);
    vlls_recovery <= rec;
    rstn          <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
  endtask
  task automatic enter_sleep(input logic [2:0] c);
    sleep_go <= 1'b1;
    lag      <= rnd[3:0];
    rnd       = lfsr(rnd);
    @(posedge clk_sys);
    sleep_go <= 1'b0;
    n = 0;
    while (pwr_ctl.core_stop !== 1'b1 && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    chk("entry stop", pwr_ctl.core_stop, 1'b1);
    chk("entry status", current_mode_status, exp_stat(c));
  endtask
  task automatic wake_up;
    wake_go <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (current_mode_status !== `MS_RUN && pwr_ctl.reset_flow_req !== 1'b1 && n < 40);
    wake_go <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    complete_run;
  end

  initial begin
    sel = `STOP_MODE_SELECT_NORMAL;
    do_reset(1'b0);
    rchk("status reset", 12'h00C, 32'h0000_0001);
    rchk("submode reset", 12'h008, 32'h0000_0013);
    chk("regulator reset", regulator_run_status, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_0003);
    rchk("select blocked", 12'h004, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0008);
    apb(1'b1, 12'h000, 32'h0000_002A);
    rchk("protection once", 12'h000, 32'h0000_0008);
    for (int i = 0; i < 16; i++) begin
      code = (i < 8) ? i[2:0] : rnd[2:0];
      rnd  = lfsr(rnd);
      apb(1'b1, 12'h004, {29'h0, code});
      sel = exp_sel(sel, code, 8'h08);
      rchk("select code", 12'h004, {29'h0, sel});
    end
    apb(1'b1, 12'h000, 32'h0000_002A);
    rchk("prot ignored", 12'h000, 32'h0000_0008);
    apb(1'b0, 12'h01C, 32'h0000_0000);
    chk("unmapped err", last_err, 1'b1);
    chk("unmapped data", rdat, 32'h0000_0000);
    $display("test registers done");
    apb(1'b1, 12'h004, 32'h0000_0003);
    apb(1'b1, 12'h018, 32'h0000_0000);
    light    <= 1'b1;
    sleep_go <= 1'b1;
    @(posedge clk_sys);
    sleep_go <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk("shallow sleep", pwr_ctl.core_stop, 1'b0);
    chk("shallow regulator", regulator_run_status, 1'b1);
    light <= 1'b0;
    enter_sleep(`STOP_MODE_SELECT_LLS);
    chk("regulator stop", regulator_run_status, 1'b0);
    wake_up;
    rchk("status woke", 12'h00C, 32'h0000_0001);
    chk("irq masked", irq, 1'b0);
    apb(1'b1, 12'h018, 32'h0000_0007);
    chk("irq raised", irq, 1'b1);
    apb(1'b1, 12'h014, 32'h0000_0007);
    chk("irq cleared", irq, 1'b0);
    sleep_go <= 1'b1;
    lag      <= 4'h0;
    @(posedge clk_sys);
    sleep_go <= 1'b0;
    repeat (3) @(posedge clk_sys);
    wake_go <= 1'b1;
    repeat (20) @(posedge clk_sys);
    wake_go <= 1'b0;
    chk("abort stop", pwr_ctl.core_stop, 1'b0);
    rchk("abort flag", 12'h004, 32'h0000_000B);
    rchk("abort status", 12'h00C, 32'h0000_0001);
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk("abort event", rdat[`EV_ABORTED], 1'b1);
    $display("test stop entry done");
    do_reset(1'b0);
    apb(1'b1, 12'h000, 32'h0000_002A);
    apb(1'b1, 12'h004, 32'h0000_0040);
    rchk("very_low_power_run status", 12'h00C, 32'h0000_0004);
    apb(1'b1, 12'h004, 32'h0000_0004);
    apb(1'b1, 12'h008, 32'h0000_0010);
    sleep_go <= 1'b1;
    @(posedge clk_sys);
    sleep_go <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk("reserved submode", pwr_ctl.core_stop, 1'b0);
    apb(1'b1, 12'h008, 32'h0000_0002);
    enter_sleep(`STOP_MODE_SELECT_VLLS);
    chk("ram2 off", pwr_ctl.ram2_power_en, 1'b0);
    wake_up;
    chk("reset flow", pwr_ctl.reset_flow_req, 1'b1);
    $display("test deep leakage done");
    do_reset(1'b1);
    repeat (4) @(posedge clk_sys);
    chk("pads held", pwr_ctl.pad_hold, 1'b1);
    rchk("iso ack", 12'h010, 32'h0000_000C);
    apb(1'b1, 12'h010, 32'h0000_0008);
    chk("pads released", pwr_ctl.pad_hold, 1'b0);
    chk("osc released", pwr_ctl.osc_hold, 1'b0);
    vlls_recovery <= 1'b0;
    $display("test isolation done");
    complete_run;
  end
endmodule
